// ---- design/ovr_defines.vh ----
/*
 * Constants for the output volume register bank: register indices,
 * byte addresses, field positions, reset value and gain decoding.
 * Assumes it is included by bare name from the design and sim files.
 */
`ifndef OVR_DEFINES_VH
`define OVR_DEFINES_VH

// register indices; the byte address is four times the index
`define OVR_IDX_LEFT_PHONES 8'h34
`define OVR_IDX_RIGHT_PHONES 8'h35
`define OVR_IDX_LEFT_SPEAKER 8'h36

// readback of the active settings and of the waiting flags
`define OVR_ADDR_ACT_LEFT_PHONES 32'h0000_00E0
`define OVR_ADDR_ACT_RIGHT_PHONES 32'h0000_00E4
`define OVR_ADDR_ACT_LEFT_SPEAKER 32'h0000_00E8
`define OVR_ADDR_STATUS 32'h0000_00EC

// field layout of one volume register
`define OVR_COMMIT_BIT 8
`define OVR_ZC_BIT 7
`define OVR_MUTE_BIT 6
`define OVR_GAIN_MSB 5

// reset value: gain code for 0 dB, all flags clear
`define OVR_VOL_RESET 9'h039

// gain code zero stands for this many dB below 0 dB
`define OVR_DB_OFFSET 7'h39

// channel numbering; the last value means no volume register
`define OVR_CH_LEFT_PHONES 2'h0
`define OVR_CH_RIGHT_PHONES 2'h1
`define OVR_CH_LEFT_SPEAKER 2'h2
`define OVR_CH_NONE 2'h3

// AHB transfer type bit that marks NONSEQ or SEQ
`define OVR_HTRANS_ACTIVE_BIT 1

`endif

// ---- design/ovr_zero_cross_gate.v ----
/*
 * Zero-crossing gate for one output channel: lets a committed gain
 * change through at once, or holds it until the channel's samples
 * change sign. Assumes one sample strobe per sample, synchronous to
 * clock, with the sample's sign bit beside it.
 */
`include "ovr_defines.vh"

module ovr_zero_cross_gate (
    input wire clock,
    input wire rst,
    input wire applyReq,
    input wire zcEnable,
    input wire sampleValid,
    input wire sampleSign,
    output wire applyNow,
    output reg waiting_reg
);

    reg lastSign_reg;
    reg haveLast_reg;
    wire crossing;

    // a crossing needs two samples; the first after reset only primes
    assign crossing = sampleValid & haveLast_reg &
                      (sampleSign != lastSign_reg); // [R18]

    // immediate when gating is off; also release a wait if it is
    // switched off meanwhile, so a change is never stuck
    assign applyNow = (applyReq & ~zcEnable) |
                      ((applyReq | waiting_reg) & zcEnable & crossing) |
                      (waiting_reg & ~zcEnable); // [R8] [R9] [R10] [R16]

    // remember the last sample's sign
    always @(posedge clock) begin
        if (rst) begin
            lastSign_reg <= 1'b0;
            haveLast_reg <= 1'b0;
        end else if (sampleValid) begin
            lastSign_reg <= sampleSign;
            haveLast_reg <= 1'b1;
        end
    end

    // waiting flag: a new request in a crossing cycle is served at once
    always @(posedge clock) begin
        if (rst) begin
            waiting_reg <= 1'b0;
        end else if (applyNow) begin
            waiting_reg <= 1'b0;
        end else if (applyReq & zcEnable) begin
            waiting_reg <= 1'b1; // [R16]
        end
    end

endmodule

// ---- design/ovr_output_volume_regs.v ----
/*
 * Output volume register bank for the left and right headphone drivers
 * and the left loudspeaker driver, reached over an AHB-Lite slave port.
 * Each register keeps a held setting; a commit bit makes the held
 * settings of a stereo pair active together, each gain gated by its own channel's zero crossings.
 * Assumes a single AHB-Lite master with word transfers only, and
 * sample strobes with sign bits from the three output paths.
 */
`include "ovr_defines.vh"

// Notes on behaviour
// R1 - left phones write without commit: hold only
// R2 - left phones commit: activate left and held right
// R3 - right phones write without commit: hold only
// R4 - right phones commit: activate right and held left
// R5 - left speaker write without commit: hold only
// R6 - left speaker commit: activate with held right speaker
// R7 - commit bit acts once, reads back zero
// R8 - left phones zero-cross enable defers gain changes
// R9 - right phones zero-cross enable defers gain changes
// R10 - left speaker zero-cross enable defers gain changes
// R11 - left phones silence bit mutes left phones
// R12 - right phones silence bit mutes right phones
// R13 - left speaker silence bit mutes left speaker
// R14 - gain code zero is -57 dB, 1 dB steps
// R15 - reset: 0 dB gain, all flags clear
// R16 - gain active only after commit, and after a zero cross when enabled
// R17 - host writes partner first, then commits the other
// R18 - zero crossing is a sign change between samples
module ovr_output_volume_regs (
    input wire clock,
    input wire rst,
    input wire hsel,
    input wire [31:0] haddr,
    input wire [1:0] htrans,
    input wire hwrite,
    input wire [2:0] hsize,
    input wire [31:0] hwdata,
    input wire hready,
    output reg hreadyout_reg,
    output reg hresp_reg,
    output reg [31:0] hrdata_reg,
    input wire [2:0] sampleValid,
    input wire [2:0] sampleSign,
    output reg [17:0] activeGainCode_reg,
    output reg [20:0] activeGainDb_reg,
    output reg [2:0] activeSilence_reg,
    output reg [2:0] activeZeroCrossEn_reg,
    output wire [2:0] zeroCrossWaiting,
    output reg rightSpeakerCommit_reg
);

    // decode a byte address to the channel of its volume register
    function [1:0] chanOf;
        input [31:0] addr;
        begin
            if (addr == {22'h00_0000, `OVR_IDX_LEFT_PHONES, 2'b00})
                chanOf = `OVR_CH_LEFT_PHONES;
            else if (addr == {22'h00_0000, `OVR_IDX_RIGHT_PHONES, 2'b00})
                chanOf = `OVR_CH_RIGHT_PHONES;
            else if (addr == {22'h00_0000, `OVR_IDX_LEFT_SPEAKER, 2'b00})
                chanOf = `OVR_CH_LEFT_SPEAKER;
            else
                chanOf = `OVR_CH_NONE;
        end
    endfunction

    // gain code to signed dB, two's complement in seven bits
    function [6:0] gainToDb;
        input [5:0] code;
        begin
            gainToDb = {1'b0, code} - `OVR_DB_OFFSET; // [R14]
        end
    endfunction

    wire [8:0] volReset;
    wire addrPhase;
    wire [1:0] wrChan;
    wire wrCommit;
    wire [1:0] rdChan;

    reg wrPend_reg;
    reg rdPend_reg;
    reg [31:0] addrPhase_reg;
    reg [2:0] commitReq_reg;
    reg [7:0] held_reg [0:2];
    reg [5:0] pendGain_reg [0:2];
    reg [31:0] rdValue;
    wire [2:0] applyNow;
    wire [2:0] zcGate;

    assign volReset = `OVR_VOL_RESET;

    // a transfer is taken only when the bus is ready
    assign addrPhase = hsel & hready & htrans[`OVR_HTRANS_ACTIVE_BIT];
    assign wrChan = chanOf(addrPhase_reg);
    assign wrCommit = hwdata[`OVR_COMMIT_BIT];
    assign rdChan = chanOf(addrPhase_reg);

    // address phase capture; a read costs one wait state so that it
    // always sees a write completed in the cycle before
    always @(posedge clock) begin
        if (rst) begin
            wrPend_reg <= 1'b0;
            rdPend_reg <= 1'b0;
            addrPhase_reg <= 32'h0000_0000;
            hreadyout_reg <= 1'b1;
            hresp_reg <= 1'b0;
        end else begin
            hresp_reg <= 1'b0;
            wrPend_reg <= addrPhase & hwrite;
            rdPend_reg <= addrPhase & ~hwrite;
            if (addrPhase) begin
                addrPhase_reg <= haddr;
            end
            if (addrPhase & ~hwrite) begin
                hreadyout_reg <= 1'b0;
            end else if (rdPend_reg) begin
                hreadyout_reg <= 1'b1;
            end
        end
    end

    // read multiplexer; unmapped addresses read zero
    always @* begin
        rdValue = 32'h0000_0000;
        case (rdChan)
            `OVR_CH_LEFT_PHONES,
            `OVR_CH_RIGHT_PHONES,
            `OVR_CH_LEFT_SPEAKER: begin
                // commit bit always reads as zero
                rdValue = {24'h00_0000, held_reg[rdChan]}; // [R7]
            end
            default: begin
                case (addrPhase_reg)
                    `OVR_ADDR_ACT_LEFT_PHONES: begin
                        rdValue = {24'h00_0000, activeZeroCrossEn_reg[0],
                                   activeSilence_reg[0],
                                   activeGainCode_reg[5:0]};
                    end
                    `OVR_ADDR_ACT_RIGHT_PHONES: begin
                        rdValue = {24'h00_0000, activeZeroCrossEn_reg[1],
                                   activeSilence_reg[1],
                                   activeGainCode_reg[11:6]};
                    end
                    `OVR_ADDR_ACT_LEFT_SPEAKER: begin
                        rdValue = {24'h00_0000, activeZeroCrossEn_reg[2],
                                   activeSilence_reg[2],
                                   activeGainCode_reg[17:12]};
                    end
                    `OVR_ADDR_STATUS: begin
                        rdValue = {29'h0000_0000, zeroCrossWaiting};
                    end
                    default: begin
                        rdValue = 32'h0000_0000;
                    end
                endcase
            end
        endcase
    end

    // read data is loaded in the wait cycle and stands until next read
    always @(posedge clock) begin
        if (rst) begin
            hrdata_reg <= 32'h0000_0000;
        end else if (rdPend_reg) begin
            hrdata_reg <= rdValue;
        end
    end

    // commit turns into a one-cycle request for the whole pair; the
    // right speaker register lives elsewhere and is told by a pulse
    always @(posedge clock) begin
        if (rst) begin
            commitReq_reg <= 3'h0;
            rightSpeakerCommit_reg <= 1'b0;
        end else begin
            commitReq_reg <= 3'h0;
            rightSpeakerCommit_reg <= 1'b0;
            if (wrPend_reg & wrCommit) begin
                case (wrChan)
                    `OVR_CH_LEFT_PHONES: begin
                        commitReq_reg <= 3'h3; // [R2]
                    end
                    `OVR_CH_RIGHT_PHONES: begin
                        commitReq_reg <= 3'h3; // [R4]
                    end
                    `OVR_CH_LEFT_SPEAKER: begin
                        commitReq_reg <= 3'h4; // [R6]
                        rightSpeakerCommit_reg <= 1'b1; // [R6]
                    end
                    default: begin
                        commitReq_reg <= 3'h0;
                    end
                endcase
            end
        end
    end

    genvar ch;
    generate
        for (ch = 0; ch < 3; ch = ch + 1) begin : gChan
            // held settings: every write lands here, the commit bit
            // itself is never stored
            always @(posedge clock) begin
                if (rst) begin
                    held_reg[ch] <= volReset[7:0]; // [R15]
                end else if (wrPend_reg && wrChan == ch) begin
                    held_reg[ch] <= hwdata[7:0]; // [R1] [R3] [R5] [R7]
                end
            end

            // gating follows the committed enable; an uncommitted write
            // that flips the held enable must not start or end a wait
            assign zcGate[ch] = commitReq_reg[ch] ?
                held_reg[ch][`OVR_ZC_BIT] :
                activeZeroCrossEn_reg[ch]; // [R16]

            ovr_zero_cross_gate uGate (
                .clock(clock),
                .rst(rst),
                .applyReq(commitReq_reg[ch]),
                .zcEnable(zcGate[ch]),
                .sampleValid(sampleValid[ch]),
                .sampleSign(sampleSign[ch]),
                .applyNow(applyNow[ch]),
                .waiting_reg(zeroCrossWaiting[ch])
            );

            // silence and gating take effect at commit; the gain is
            // snapshotted so later uncommitted writes cannot leak in
            always @(posedge clock) begin
                if (rst) begin
                    activeSilence_reg[ch] <= 1'b0; // [R15]
                    activeZeroCrossEn_reg[ch] <= 1'b0; // [R15]
                    pendGain_reg[ch] <= volReset[`OVR_GAIN_MSB:0];
                end else if (commitReq_reg[ch]) begin
                    // muting cuts the driver off its mixer stage
                    activeSilence_reg[ch] <=
                        held_reg[ch][`OVR_MUTE_BIT]; // [R11] [R12] [R13]
                    activeZeroCrossEn_reg[ch] <= held_reg[ch][`OVR_ZC_BIT];
                    pendGain_reg[ch] <= held_reg[ch][`OVR_GAIN_MSB:0];
                end
            end

            // active gain moves only when the gate opens
            always @(posedge clock) begin
                if (rst) begin
                    activeGainCode_reg[ch*6 +: 6] <=
                        volReset[`OVR_GAIN_MSB:0]; // [R15]
                    activeGainDb_reg[ch*7 +: 7] <=
                        gainToDb(volReset[`OVR_GAIN_MSB:0]);
                end else if (applyNow[ch]) begin
                    if (commitReq_reg[ch]) begin
                        activeGainCode_reg[ch*6 +: 6] <=
                            held_reg[ch][`OVR_GAIN_MSB:0]; // [R16]
                        activeGainDb_reg[ch*7 +: 7] <=
                            gainToDb(held_reg[ch][`OVR_GAIN_MSB:0]);
                    end else begin
                        activeGainCode_reg[ch*6 +: 6] <=
                            pendGain_reg[ch]; // [R16]
                        activeGainDb_reg[ch*7 +: 7] <=
                            gainToDb(pendGain_reg[ch]); // [R14]
                    end
                end
            end
        end
    endgenerate

endmodule

// ---- sim/ovr_output_volume_regs_monitor.sv ----
/* checker for the output volume bank: commit, hold, zero-cross and
   gain decode relations. Sees only the top module's ports. */
`include "ovr_defines.vh"
module ovr_output_volume_regs_monitor (
    input wire clock,
    input wire rst,
    input wire hsel,
    input wire [31:0] haddr,
    input wire [1:0] htrans,
    input wire hwrite,
    input wire [31:0] hwdata,
    input wire hready,
    input wire [31:0] hrdata_reg,
    input wire [2:0] sampleValid,
    input wire [2:0] sampleSign,
    input wire [17:0] activeGainCode_reg,
    input wire [20:0] activeGainDb_reg,
    input wire [2:0] activeSilence_reg,
    input wire [2:0] zeroCrossWaiting,
    input wire rightSpeakerCommit_reg
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking @(posedge clock); endclocking
    default disable iff (rst);
    localparam logic [31:0] SPK = `OVR_IDX_LEFT_SPEAKER * 4;
    reg wPh_reg, rPh_reg, cmtLast_reg, seen_reg, lastSign_reg;
    reg [31:0] wAd_reg;
    reg spkCmtLast_reg;
    wire wEnd = wPh_reg && hready;
    wire cmtNow = wEnd && hwdata[8];
    // code minus 57, seven bits per channel
    wire [20:0] dbExp = {{1'b0, activeGainCode_reg[17:12]} - 7'd57,
        {1'b0, activeGainCode_reg[11:6]} - 7'd57,
        {1'b0, activeGainCode_reg[5:0]} - 7'd57};
    // data phase tracking moves only while the bus is ready; commit history updates every cycle, sample sign history on each channel 0 strobe
    always @(posedge clock) begin
        cmtLast_reg <= cmtNow && !rst;
        spkCmtLast_reg <= cmtNow && wAd_reg == SPK && !rst;
        if (sampleValid[0]) begin
            lastSign_reg <= sampleSign[0];
            seen_reg <= 1'b1;
        end
        if (rst)
            seen_reg <= 1'b0;
        if (rst || hready) begin
            wPh_reg <= !rst && hsel && htrans[1] && hwrite;
            rPh_reg <= !rst && hsel && htrans[1] && !hwrite;
            wAd_reg <= haddr;
        end
    end
    property commitApply(logic [31:0] ad, int i);
        cmtNow && wAd_reg == ad && !hwdata[7] |-> ##2
            activeGainCode_reg[6*i +: 6] == $past(hwdata[5:0], 2) &&
            activeSilence_reg[i] == $past(hwdata[6], 2);
    endproperty
    AST_LP_COMMIT: assert property (commitApply(SPK - 8, 0))
        else $error("left phones commit not applied");
    AST_RP_COMMIT: assert property (commitApply(SPK - 4, 1))
        else $error("right phones commit not applied");
    AST_SPK_COMMIT: assert property (commitApply(SPK, 2))
        else $error("speaker commit not applied");
    AST_SPK_PULSE: assert property (cmtNow && wAd_reg == SPK |=>
        rightSpeakerCommit_reg) else $error("partner commit pulse missing");
    AST_SPK_CAUSE: assert property (rightSpeakerCommit_reg |->
        spkCmtLast_reg) else $error("stray partner pulse");
    AST_HOLD: assert property (wEnd && !hwdata[8] &&
        !cmtLast_reg && zeroCrossWaiting == 3'b000 |=>
        $stable({activeGainCode_reg, activeSilence_reg}) [*2])
        else $error("uncommitted write changed active settings");
    AST_DB: assert property (activeGainDb_reg == dbExp)
        else $error("gain decode wrong");
    AST_ZC_HOLD: assert property (zeroCrossWaiting[0] &&
        !sampleValid[0] && !cmtLast_reg |=>
        $stable(activeGainCode_reg[5:0])) else $error("gain left early");
    AST_ZC_APPLY: assert property (zeroCrossWaiting[0] &&
        sampleValid[0] && seen_reg && sampleSign[0] != lastSign_reg &&
        !cmtLast_reg |=> !zeroCrossWaiting[0])
        else $error("crossing did not apply gain");
    AST_RD_NO_COMMIT: assert property (rPh_reg && hready |->
        !hrdata_reg[8]) else $error("commit bit read back");
    // main scenarios
    cover property (cmtNow && wAd_reg == SPK);
    cover property (zeroCrossWaiting[0] && sampleValid[0]);
    cover property (rPh_reg && hready);
endmodule
bind ovr_output_volume_regs ovr_output_volume_regs_monitor u_mon (
    .clock(clock),
    .rst(rst),
    .hsel(hsel),
    .haddr(haddr),
    .htrans(htrans),
    .hwrite(hwrite),
    .hwdata(hwdata),
    .hready(hready),
    .hrdata_reg(hrdata_reg),
    .sampleValid(sampleValid),
    .sampleSign(sampleSign),
    .activeGainCode_reg(activeGainCode_reg),
    .activeGainDb_reg(activeGainDb_reg),
    .activeSilence_reg(activeSilence_reg),
    .zeroCrossWaiting(zeroCrossWaiting),
    .rightSpeakerCommit_reg(rightSpeakerCommit_reg)
);

// ---- sim/ovr_output_volume_regs_bench.sv ----
/* bench for the output volume bank: word reads and writes over
   AHB-Lite, sample strobes driven directly. Needs the design alone. */
`include "ovr_defines.vh"
module ovr_output_volume_regs_bench;
    timeunit 1ns;
    timeprecision 1ps;
    localparam logic [31:0] LP = `OVR_IDX_LEFT_PHONES * 4;
    localparam logic [17:0] OLD = {6'h00, 6'h05, 6'h3F};
    logic clock = 0, rst = 1, hsel = 0, hwrite = 0;
    logic [31:0] haddr = '0, hwdata = '0, rdat;
    logic [1:0] htrans = '0;
    logic [2:0] hsize = 3'h2, sampleValid = '0, sampleSign = '0;
    wire hready, hreadyout_reg, hresp_reg, rightSpeakerCommit_reg;
    wire [31:0] hrdata_reg;
    wire [17:0] activeGainCode_reg;
    wire [20:0] activeGainDb_reg;
    wire [2:0] activeSilence_reg, activeZeroCrossEn_reg, zeroCrossWaiting;
    int n_fail = 0, cmp_count = 0;
    assign hready = hreadyout_reg;
    ovr_output_volume_regs u_ovr_output_volume_regs (
        .clock(clock),
        .rst(rst),
        .hsel(hsel),
        .haddr(haddr),
        .htrans(htrans),
        .hwrite(hwrite),
        .hsize(hsize),
        .hwdata(hwdata),
        .hready(hready),
        .hreadyout_reg(hreadyout_reg),
        .hresp_reg(hresp_reg),
        .hrdata_reg(hrdata_reg),
        .sampleValid(sampleValid),
        .sampleSign(sampleSign),
        .activeGainCode_reg(activeGainCode_reg),
        .activeGainDb_reg(activeGainDb_reg),
        .activeSilence_reg(activeSilence_reg),
        .activeZeroCrossEn_reg(activeZeroCrossEn_reg),
        .zeroCrossWaiting(zeroCrossWaiting),
        .rightSpeakerCommit_reg(rightSpeakerCommit_reg)
    );
    initial forever #4 clock = ~clock;
    task automatic tally_and_finish();
        $display("compares %0d mismatches %0d", cmp_count, n_fail);
        if (n_fail == 0 && cmp_count > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask
    task automatic chk(input [31:0] got, exp, input string w);
        cmp_count++;
        if (got !== exp) begin
            n_fail++;
            $display("[ERR] %0t %s got %h exp %h", $time, w, got, exp);
        end
    endtask
    // bounded wait for an edge that samples ready high
    task automatic waitRdy();
        int k = 0;
        @(posedge clock);
        while (hready !== 1'b1 && k < 50) begin
            @(posedge clock);
            k++;
        end
        if (hready !== 1'b1) begin
            n_fail++;
            tally_and_finish();
        end
    endtask
    task automatic xfer(input bit wr, input [31:0] a, wd);
        hsel <= 1'b1;
        haddr <= a;
        hwrite <= wr;
        htrans <= 2'b10;
        waitRdy();
        hsel <= 1'b0;
        htrans <= 2'b00;
        hwdata <= wd;
        waitRdy();
        rdat = hrdata_reg;
    endtask
    task automatic rdc(input [31:0] a, exp, input string w);
        xfer(0, a, 32'h0);
        chk(rdat, exp, w);
        chk(hresp_reg, 1'b0, "okay");
    endtask
    // one strobe pulse, then one quiet cycle
    task automatic strobe(input [2:0] v, s);
        sampleValid <= v;
        sampleSign <= s;
        @(posedge clock);
        sampleValid <= 3'b000;
        @(posedge clock);
    endtask
    initial begin
        repeat (10) @(posedge clock);
        rst <= 1'b0;
        @(posedge clock);
        for (int i = 0; i < 3; i++)
            rdc(LP + 4 * i, 32'h0000_0039, "reset held");
        rdc(32'h0000_0040, 32'h0, "unmapped");
        chk(activeGainCode_reg, {3{6'h39}}, "reset gain");
        chk(activeGainDb_reg, 21'h0, "reset db");
        chk({activeSilence_reg, activeZeroCrossEn_reg}, 6'h0, "off");
        $display("test reset done");
        xfer(1, LP, 32'h0000_0010);
        repeat (3) @(posedge clock);
        chk(activeGainCode_reg, {3{6'h39}}, "held only");
        rdc(LP, 32'h0000_0010, "held readback");
        xfer(1, LP + 4, 32'h0000_0160);
        repeat (3) @(posedge clock);
        chk(activeGainCode_reg, {6'h39, 6'h20, 6'h10}, "pair");
        chk(activeSilence_reg, 3'b010, "right mute");
        chk(activeGainDb_reg, {7'h00, 7'h67, 7'h57}, "db");
        rdc(`OVR_ADDR_ACT_RIGHT_PHONES, 32'h0000_0060, "active");
        rdc(LP + 4, 32'h0000_0060, "commit reads 0");
        xfer(1, LP + 4, 32'h0000_0005);
        repeat (3) @(posedge clock);
        chk(activeGainCode_reg[11:6], 6'h20, "right held");
        xfer(1, LP, 32'h0000_017F);
        repeat (3) @(posedge clock);
        chk(activeGainCode_reg, {6'h39, 6'h05, 6'h3F}, "pair");
        chk(activeSilence_reg, 3'b001, "left mute");
        chk(activeGainDb_reg[6:0], 7'h06, "top code");
        $display("test phones done");
        xfer(1, LP + 8, 32'h0000_0040);
        @(posedge clock);
        chk(rightSpeakerCommit_reg, 1'b0, "no pulse");
        repeat (2) @(posedge clock);
        chk(activeGainCode_reg[17:12], 6'h39, "spk held");
        xfer(1, LP + 8, 32'h0000_0140);
        @(posedge clock);
        chk(rightSpeakerCommit_reg, 1'b1, "partner pulse");
        @(posedge clock);
        chk(activeGainCode_reg[17:12], 6'h00, "spk gain");
        chk(activeSilence_reg[2], 1'b1, "spk mute");
        chk(activeGainDb_reg[20:14], 7'h47, "bottom code");
        $display("test speaker done");
        // zero-cross gating, each channel in turn, after priming signs
        strobe(3'b111, 3'b000);
        for (int ch = 0; ch < 3; ch++) begin
            xfer(1, LP + 4 * ch, 32'h0000_018A);
            repeat (3) @(posedge clock);
            chk(zeroCrossWaiting[ch], 1'b1, "waiting");
            chk(activeZeroCrossEn_reg[ch], 1'b1, "zc on");
            strobe(3'b001 << ch, 3'b000);
            chk(activeGainCode_reg[6*ch +: 6], OLD[6*ch +: 6], "old");
            strobe(3'b001 << ch, 3'b111);
            chk(activeGainCode_reg[6*ch +: 6], 6'h0A, "crossed");
            chk(zeroCrossWaiting[ch], 1'b0, "released");
        end
        // the right phones commit re-armed the left phones wait
        rdc(`OVR_ADDR_STATUS, 32'h0000_0001, "status");
        $display("test zero cross done");
        tally_and_finish();
    end
endmodule
